// ===== hw/rt_extended_options_regs.svh
// offsets, field positions and reset values of the rt global options register
`ifndef RT_EXTENDED_OPTIONS_REGS_SVH
`define RT_EXTENDED_OPTIONS_REGS_SVH
`define RT_GLOBAL_OPTIONS_ADDR   16'h004d
`define RT_GLOBAL_OPTIONS_RESET  16'h0000
`define RT_GLOBAL_OPTIONS_MASK   16'h003e
`define OPT_PP_SUPPRESS_BIT      1
`define OPT_BUSY_REPORT_BIT      2
`define OPT_BCAST_SELECT_BIT     3
`define IIW_BUSY_AT_EVENT_BIT    9
`define MIW_GAP_OR_BROADCAST_FLAG_BIT        13
`endif

// ===== hw/rt_extended_options_pkg.sv
// types shared by the rt global options block
package rt_extended_options_pkg;
  typedef struct packed {
    logic        ev_valid;     // enabled interrupt event
    logic [15:0] ev_flags;     // event's own flag bits
    logic        rt_busy;      // terminal busy during event
  } irq_event_s;
  typedef struct packed {
    logic        msg_done;     // message finished
    logic        gap_error;    // gap error seen
    logic        broadcast;    // broadcast command
    logic        illegal;      // valid illegal command
    logic        busy_end;     // message ended with busy status
    logic        legal_ok;     // legal message without error
    logic        sel_in;       // current buffer selector
  } msg_event_s;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_LOG  = 2'b10
  } log_state_e;
endpackage

// ===== hw/rt_option_store.sv
// option register storage with masked write and masked read back
`timescale 1ns/100ps
`include "rt_extended_options_regs.svh"
module rt_option_store #(
  parameter int WIDTH = 16
) (
  // clock and reset
  input  wire logic             i_mclk,
  input  wire logic             i_rstn,
  // write port
  input  wire logic             i_we,
  input  wire logic [WIDTH-1:0] i_wdata,
  // stored value
  output logic      [WIDTH-1:0] o_value
);
  logic [WIDTH-1:0] value_q;
  logic [WIDTH-1:0] value_d;

  // only the 16-bit option layout is served; refuse anything else at elaboration
  if (WIDTH != 16) begin : g_width_check
    $error("rt_option_store: width must be 16");
  end

  always_comb begin
    value_d = value_q;
    if (i_we) begin
      value_d = i_wdata & `RT_GLOBAL_OPTIONS_MASK;
    end
  end

  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      value_q <= `RT_GLOBAL_OPTIONS_RESET;
    end else begin
      value_q <= value_d;
    end
  end

  assign o_value = value_q;
endmodule

// ===== hw/rt_extended_options.sv
// rt global options register and the message/interrupt logging it steers
//
// What this block does
// - select bit 0: message word bit 13 carries gap error
// - select bit 1: message word bit 13 carries broadcast
// - busy report on: busy during enabled event sets logged bit 9
// - not busy: only the event's own flags are logged
// - busy report off: logged bit 9 always zero
// - log entries only for enabled events, never for busy alone
// - pending interrupt register bit 9 unaffected, stays reserved
// - suppress set: no selector toggle for illegal or busy messages
//
// register port: one word at the options offset; writes land on the strobe edge,
//   read data and its valid follow one clock after the read strobe, for one clock
// interrupt events: an accepted event shows its pending flags one clock later and
//   its logged word with the log strobe two clocks later
// an event offered in the clock right after an accepted one is lost; the
//   interrupt source must space events at least two clocks apart
// message completion: info word bit 13 and the new buffer selector follow the
//   completion strobe by one clock and then hold until the next message
// trade-off: the logged word is staged once more so the busy flag uses the
//   options that stood when the event was taken, not a later write
// limitation: reserved option bits are stored and read back but steer nothing
`timescale 1ns/100ps
`include "rt_extended_options_regs.svh"
module rt_extended_options
  import rt_extended_options_pkg::*;
(
  // clock and reset
  input  wire logic                               i_mclk,
  input  wire logic                               i_rstn,
  // register port
  input  wire logic                               i_reg_wr,
  input  wire logic                               i_reg_rd,
  input  wire logic [15:0]                        i_reg_addr,
  input  wire logic [15:0]                        i_reg_wdata,
  output logic      [15:0]                        o_reg_rdata,
  output logic                                    o_reg_rvalid,
  // interrupt event in, log word out
  input  wire rt_extended_options_pkg::irq_event_s i_irq_event,
  output logic                                    o_log_we,
  output logic      [15:0]                        o_interrupt_identification_word,
  output logic      [15:0]                        o_pending_set,
  // message completion in, info word and selector out
  input  wire rt_extended_options_pkg::msg_event_s i_msg_event,
  output logic                                    o_miw_valid,
  output logic      [15:0]                        o_miw_flags,
  output logic                                    o_pingpong_buffer_selector
);
  import rt_extended_options_pkg::*;

  logic        opt_we;
  logic [15:0] opt_value;
  logic        broadcast_flag_select;
  logic        busy_report_enable;
  logic        pingpong_toggle_suppress;

  // word with a single chosen bit; shared by the log and message paths
  function automatic logic [15:0] bit_at(input int pos, input logic val);
    logic [15:0] w;
    w = 16'h0000;
    w[pos] = val;
    return w;
  endfunction

  // register decode, exact address only
  // a write to any other offset is ignored, nothing else sits behind this port
  assign opt_we = i_reg_wr && (i_reg_addr == `RT_GLOBAL_OPTIONS_ADDR);

  rt_option_store #(
    .WIDTH (16)
  ) u_store (
    .i_mclk  (i_mclk),
    .i_rstn  (i_rstn),
    .i_we    (opt_we),
    .i_wdata (i_reg_wdata),
    .o_value (opt_value)
  );

  // reserved bits 5:4 are stored as written; software leaves them clear
  assign broadcast_flag_select    = opt_value[`OPT_BCAST_SELECT_BIT];
  assign busy_report_enable       = opt_value[`OPT_BUSY_REPORT_BIT];
  assign pingpong_toggle_suppress = opt_value[`OPT_PP_SUPPRESS_BIT];

  // read back, registered; other addresses read zero
  logic [15:0] rdata_q, rdata_d;
  logic        rvalid_q, rvalid_d;
  // the read port never stalls, so every read is answered whatever the address
  always_comb begin
    rvalid_d = i_reg_rd;
    rdata_d  = 16'h0000;
    if (i_reg_rd && (i_reg_addr == `RT_GLOBAL_OPTIONS_ADDR)) begin
      rdata_d = opt_value & `RT_GLOBAL_OPTIONS_MASK;
    end
  end

  // interrupt log path, two-state sequencer
  log_state_e  state_q, state_d;
  logic [15:0] iiw_q, iiw_d;
  logic [15:0] iiw_hold_q, iiw_hold_d;
  logic        log_we_q, log_we_d;
  logic [15:0] pend_q, pend_d;
  always_comb begin
    state_d    = state_q;
    iiw_d      = iiw_q;
    iiw_hold_d = iiw_hold_q;
    log_we_d   = 1'b0;
    pend_d     = 16'h0000;
    // the pending strobe is cleared every clock and pulses only on acceptance
    case (state_q)
      ST_IDLE: begin
        if (i_irq_event.ev_valid) begin
          iiw_hold_d = i_irq_event.ev_flags & ~bit_at(`IIW_BUSY_AT_EVENT_BIT, 1'b1);
          iiw_hold_d = iiw_hold_d | bit_at(`IIW_BUSY_AT_EVENT_BIT,
                                           busy_report_enable & i_irq_event.rt_busy);
          pend_d  = i_irq_event.ev_flags & ~bit_at(`IIW_BUSY_AT_EVENT_BIT, 1'b1);
          state_d = ST_LOG;
        end
      end
      ST_LOG: begin
        // events here are dropped; partner spaces them two cycles apart
        iiw_d    = iiw_hold_q;
        log_we_d = 1'b1;
        state_d  = ST_IDLE;
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // message information word and buffer selector
  logic [15:0] miw_q, miw_d;
  logic        miw_valid_q, miw_valid_d;
  logic        sel_q, sel_d;
  logic        toggle;
  always_comb begin
    miw_valid_d = i_msg_event.msg_done;
    miw_d       = miw_q;
    sel_d       = sel_q;
    toggle      = 1'b0;
    // the info word is rebuilt on each completion; only bit 13 is owned here
    if (i_msg_event.msg_done) begin
      miw_d = bit_at(`MIW_GAP_OR_BROADCAST_FLAG_BIT, broadcast_flag_select ? i_msg_event.broadcast
                                                               : i_msg_event.gap_error);
      // legal messages ending in error arrive with legal_ok low and never toggle
      // suppress selector toggle
      if (pingpong_toggle_suppress) begin
        toggle = i_msg_event.legal_ok && !i_msg_event.illegal && !i_msg_event.busy_end;
      end else begin
        toggle = i_msg_event.legal_ok || i_msg_event.illegal || i_msg_event.busy_end;
      end
      sel_d = i_msg_event.sel_in ^ toggle;
    end
  end

  // read answer registers; the valid strobe lives for exactly one clock,
  // so a host that misses it must issue the read again
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      rdata_q  <= 16'h0000;
      rvalid_q <= 1'b0;
    end else begin
      rdata_q  <= rdata_d;
      rvalid_q <= rvalid_d;
    end
  end

  // interrupt log registers; the held word is cleared too, so no stale
  // flags can reach the log after a reset
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      state_q    <= ST_IDLE;
      iiw_q      <= 16'h0000;
      iiw_hold_q <= 16'h0000;
      log_we_q   <= 1'b0;
      pend_q     <= 16'h0000;
    end else begin
      state_q    <= state_d;
      iiw_q      <= iiw_d;
      iiw_hold_q <= iiw_hold_d;
      log_we_q   <= log_we_d;
      pend_q     <= pend_d;
    end
  end

  // message word and selector registers; the selector holds between messages
  // so the buffer choice stays stable while the next message is stored
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      miw_q       <= 16'h0000;
      miw_valid_q <= 1'b0;
      sel_q       <= 1'b0;
    end else begin
      miw_q       <= miw_d;
      miw_valid_q <= miw_valid_d;
      sel_q       <= sel_d;
    end
  end

  // every output comes straight from a register of its group
  assign o_reg_rdata                     = rdata_q;
  assign o_reg_rvalid                    = rvalid_q;
  assign o_log_we                        = log_we_q;
  assign o_interrupt_identification_word = iiw_q;
  assign o_pending_set                   = pend_q;
  assign o_miw_valid                     = miw_valid_q;
  assign o_miw_flags                     = miw_q;
  assign o_pingpong_buffer_selector      = sel_q;
endmodule

// ===== verif/rt_options_monitor.sv
// port assertions for the rt global options block
`timescale 1ns/100ps
module rt_options_monitor
  import rt_extended_options_pkg::*;
(
  // watched ports
  input wire logic        i_mclk, i_rstn, i_reg_wr, i_reg_rd, o_reg_rvalid, o_log_we, o_miw_valid,
  input wire logic        o_pingpong_buffer_selector,
  input wire logic [15:0] i_reg_addr, i_reg_wdata, o_reg_rdata, o_interrupt_identification_word,
  input wire logic [15:0] o_pending_set, o_miw_flags,
  input wire irq_event_s  i_irq_event,
  input wire msg_event_s  i_msg_event
);
  logic [15:0] opt_q;
  logic [15:0] opt_d;
  logic        ev_new;
  // mirror of the stored options, so expectations need no peek inside
  always_comb opt_d = (i_reg_wr && i_reg_addr == 16'h004d) ? (i_reg_wdata & 16'h003e) : opt_q;
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) opt_q <= 16'h0000;
    else opt_q <= opt_d;
  end
  // an event right after an accepted one is dropped, so only fresh ones count
  assign ev_new = i_irq_event.ev_valid;
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_rstn);
  rd_value_a: assert property (i_reg_rd |=> o_reg_rvalid && o_reg_rdata ==
    ($past(i_reg_addr) == 16'h004d ? $past(opt_q) : 16'h0000)) else $error("read data wrong");
  log_value_a: assert property (ev_new && !$past(ev_new) |-> ##2 o_log_we &&
    o_interrupt_identification_word == (($past(i_irq_event.ev_flags, 2) & 16'hfdff) |
    {6'h00, $past(opt_q[2] && i_irq_event.rt_busy, 2), 9'h000})) else $error("log word wrong");
  busy_off_a: assert property (ev_new && !$past(ev_new) && !opt_q[2]
    |-> ##2 !o_interrupt_identification_word[9]) else $error("busy flag logged while off");
  log_cause_a: assert property (o_log_we |-> $past(ev_new, 2)) else $error("log without event");
  pend_clear_a: assert property (ev_new && !$past(ev_new)
    |=> o_pending_set == ($past(i_irq_event.ev_flags) & 16'hfdff)) else $error("pending bit 9 set");
  gap_flag_a: assert property (i_msg_event.msg_done && !opt_q[3]
    |=> o_miw_valid && o_miw_flags[13] == $past(i_msg_event.gap_error)) else $error("gap flag wrong");
  bcast_flag_a: assert property (i_msg_event.msg_done && opt_q[3]
    |=> o_miw_flags[13] == $past(i_msg_event.broadcast)) else $error("broadcast flag wrong");
  no_toggle_a: assert property (i_msg_event.msg_done && opt_q[1] && (i_msg_event.illegal ||
    i_msg_event.busy_end) |=> o_pingpong_buffer_selector == $past(i_msg_event.sel_in)) else $error("toggled");
  cover property (o_log_we && o_interrupt_identification_word[9]);
  cover property (o_miw_valid && opt_q[1]);
  cover property (o_reg_rvalid && o_reg_rdata != 16'h0000);
endmodule
bind rt_extended_options rt_options_monitor rt_options_monitor_i (.*);

// ===== verif/host_model.sv
// host processor model issuing option register accesses
`timescale 1ns/100ps
module host_model (
  // clock and read answer
  input  wire logic        i_mclk,
  input  wire logic [15:0] i_rdata,
  input  wire logic        i_rvalid,
  // register requests
  output logic             o_wr,
  output logic             o_rd,
  output logic      [15:0] o_addr,
  output logic      [15:0] o_wdata
);
  initial begin
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_addr = 16'h0000;
    o_wdata = 16'h0000;
  end
  task automatic wr_reg(input logic [15:0] a, input logic [15:0] d);
    @(posedge i_mclk);
    o_wr <= 1'b1;
    o_addr <= a;
    o_wdata <= d & 16'hffcf;
    @(posedge i_mclk);
    o_wr <= 1'b0;
    o_wdata <= ~d;
  endtask
  // read answer stands for the clock after the strobe edge; take it mid-cycle
  task automatic rd_reg(input logic [15:0] a, output logic [15:0] d);
    @(posedge i_mclk);
    o_rd <= 1'b1;
    o_addr <= a;
    @(posedge i_mclk);
    o_rd <= 1'b0;
    @(negedge i_mclk);
    d = i_rvalid ? i_rdata : 16'hdead;
  endtask
endmodule

// ===== verif/tb_top.sv
// self-checking bench for the rt global options block
`timescale 1ns/100ps
module tb_top;
  import rt_extended_options_pkg::*;
  logic       i_mclk, i_rstn, wr, rd, rvalid, log_we, miw_valid, sel;
  logic [15:0] addr, wdata, rdata, interrupt_identification_word, pend, miw, v;
  irq_event_s ev;
  msg_event_s msg;
  int         num_errors, tests_run, cyc;
  rt_extended_options rt_extended_options_i (.i_mclk, .i_rstn, .i_reg_wr(wr), .i_reg_rd(rd),
    .i_reg_addr(addr), .i_reg_wdata(wdata), .o_reg_rdata(rdata), .o_reg_rvalid(rvalid), .i_irq_event(ev),
    .o_log_we(log_we), .o_interrupt_identification_word(interrupt_identification_word), .o_pending_set(pend), .i_msg_event(msg),
    .o_miw_valid(miw_valid), .o_miw_flags(miw), .o_pingpong_buffer_selector(sel));
  host_model host_model_i (.i_mclk, .i_rdata(rdata), .i_rvalid(rvalid), .o_wr(wr), .o_rd(rd),
    .o_addr(addr), .o_wdata(wdata));
  task chk(input string n, input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", n, exp, got);
    end
  endtask
  task give_verdict;
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task t_reg;
    host_model_i.rd_reg(16'h004d, v);
    chk("reset", v, 16'h0000);
    host_model_i.wr_reg(16'h004d, 16'hffff);
    host_model_i.rd_reg(16'h004d, v);
    chk("masked", v, 16'h000e);
    host_model_i.rd_reg(16'h004e, v);
    chk("unmapped", v, 16'h0000);
    $display("register test done");
  endtask
  // input bit 9 is set on purpose: only the busy option may drive it
  task t_irq;
    for (int i = 0; i < 4; i++) begin
      host_model_i.wr_reg(16'h004d, {13'h0000, i[1], 2'b00});
      @(posedge i_mclk) ev <= '{1'b1, 16'h0e55, i[0]};
      @(posedge i_mclk) ev.ev_valid <= 1'b0;
      #1 chk("pending", pend, 16'h0c55);
      @(posedge i_mclk) #1 chk("log", log_we, 16'h0001);
      chk("iiw", interrupt_identification_word, 16'h0c55 | {6'h00, i[1] & i[0], 9'h000});
    end
    repeat (3) @(posedge i_mclk) #1 chk("busy only", log_we, 16'h0000);
    $display("interrupt test done");
  endtask
  task t_msg;
    for (int i = 0; i < 12; i++) begin
      host_model_i.wr_reg(16'h004d, {12'h000, i[0], 1'b0, i[1], 1'b0});
      @(posedge i_mclk) msg <= '{1'b1, i[2], !i[2], i / 4 == 1, i / 4 == 2, i / 4 == 0, i[0]};
      @(posedge i_mclk) msg.msg_done <= 1'b0;
      #1 chk("gap_or_broadcast_flag", miw[13], i[0] ? !i[2] : i[2]);
      chk("info valid", miw_valid, 16'h0001);
      chk("selector", sel, i[0] ^ (!i[1] || i / 4 == 0));
    end
    $display("message test done");
  endtask
  initial begin
    i_mclk = 1'b0;
    forever #5 i_mclk = ~i_mclk;
  end
  // hang guard well above the hundred or so cycles the tests need
  always @(posedge i_mclk) begin
    cyc++;
    if (cyc == 3000) begin
      num_errors++;
      give_verdict();
    end
  end
  initial begin
    num_errors = 0;
    tests_run = 0;
    cyc = 0;
    ev = '0;
    msg = '0;
    i_rstn = 1'b0;
    repeat (10) @(posedge i_mclk);
    i_rstn <= 1'b1;
    t_reg();
    t_irq();
    t_msg();
    give_verdict();
  end
endmodule
